//--- shared/wlr_defines.svh
// Register indices, field positions, reset values and timing for the wake and link report block
`ifndef WLR_DEFINES_SVH
`define WLR_DEFINES_SVH

// Register indices; byte address is four times the index
`define WLR_IDX_MON        8'h1d
`define WLR_IDX_SWRST      8'h20
`define WLR_IDX_PHY_STAT   8'h21
`define WLR_IDX_PHY_CTL    8'h22
`define WLR_IDX_CFG        8'h30
`define WLR_IDX_RPT        8'h31
`define WLR_IDX_STAT       8'h32

// Field positions
`define WLR_PSEL_BIT       0
`define WLR_AUTO_PHY_SELECT_BIT       1
`define WLR_WAKE_ON_LINKUP_BIT       1
`define WLR_WAKE_ON_MAGIC_BIT       2
`define WLR_CLRBO_BIT      1
`define WLR_CFG_PRI_LSB    0
`define WLR_CFG_SEC_LSB    8
`define WLR_CFG_RWU_BIT    16
`define WLR_RPT_HI_LSB     8
`define WLR_RPT_LO_LSB     0
`define WLR_ST_PRI_BIT     0
`define WLR_ST_SEC_BIT     1
`define WLR_ST_FLE_BIT     2
`define WLR_ST_INT_BIT     3
`define WLR_ST_EMB_BIT     4
`define WLR_ST_SUSP_BIT    5
`define WLR_PHY_ID_W       5

// Reset values
`define WLR_PSEL_RST       1'b1
`define WLR_AUTO_PHY_SELECT_RST       1'b1
`define WLR_WAKE_EN_RST    1'b0
`define WLR_PRI_ID_RST     5'h10
`define WLR_SEC_ID_RST     5'h01
`define WLR_RPT_ADDR_RST   16'h0001

// Report layout
`define WLR_RPT_HDR        8'ha1
`define WLR_RPT_PAD        8'h00
`define WLR_RPT_STAT_LSB   40
`define WLR_RPT_HI_POS     16
`define WLR_RPT_LO_POS     0

// Management poll of link status
`define WLR_BMSR_ADDR      5'h01
`define WLR_BMSR_LINK_BIT  2
`define WLR_CLK_MHZ        25
`define WLR_POLL_US        1000
`define WLR_POLL_CYCLES    (`WLR_POLL_US * `WLR_CLK_MHZ)

`endif

//--- shared/wlr_pkg.sv
// Types of the wake and link report block
package wlr_pkg;

	typedef enum logic [1:0] {
		WLR_RUN  = 2'b00,
		WLR_SUSP = 2'b01,
		WLR_WAKE = 2'b11
	} wlr_wake_state_t;

	typedef enum logic {
		WLR_POLL_WAIT  = 1'b0,
		WLR_POLL_ISSUE = 1'b1
	} wlr_poll_state_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
		logic        auto_sel;
		logic        phy_sel;
		logic        wake_lu;
		logic        wake_mp;
		logic        clr_bo;
		logic [4:0]  pri_id;
		logic [4:0]  sec_id;
		logic        remote_wake_flag;
		logic [15:0] rpt_addr;
		logic        frame_length_error;
		logic        phy_int;
		logic        emb_active;
		logic [63:0] report;
	} wlr_top_st_t;

	typedef struct packed {
		wlr_poll_state_t state;
		logic [15:0]     timer;
		logic [1:0]      idx;
		logic            req;
		logic [4:0]      phy;
		logic [4:0]      reg_addr;
		logic            link_pri;
		logic            link_sec;
		logic [15:0]     hi_val;
		logic [15:0]     lo_val;
	} wlr_poll_st_t;

	typedef struct packed {
		wlr_wake_state_t state;
		logic            remote_wake;
		logic [1:0]      link_q;
		logic            ext_q;
	} wlr_wake_st_t;

endpackage : wlr_pkg

//--- shared/wlr_core_if.sv
// Carrier between the top, the management poller and the wake logic
`timescale 1ns/10ps
`default_nettype none
interface wlr_core_if;
	logic [4:0]  pri_id;
	logic [4:0]  sec_id;
	logic [15:0] rpt_addr;
	logic        mgmt_ack;
	logic [15:0] mgmt_rdata;
	logic        mgmt_req;
	logic [4:0]  mgmt_phy;
	logic [4:0]  mgmt_reg;
	logic        link_pri;
	logic        link_sec;
	logic [15:0] hi_val;
	logic [15:0] lo_val;
	logic        remote_wake_flag;
	logic        setfeat_en;
	logic        wake_lu;
	logic        wake_mp;
	logic        magic;
	logic        host_resume;
	logic        suspend_req;
	logic        ext_wake_n;
	logic        suspended;
	logic        remote_wake;

	modport poll (input pri_id, sec_id, rpt_addr, mgmt_ack, mgmt_rdata,
		output mgmt_req, mgmt_phy, mgmt_reg, link_pri, link_sec, hi_val, lo_val);
	modport wake (input remote_wake_flag, setfeat_en, wake_lu, wake_mp, magic, host_resume, suspend_req,
		ext_wake_n, link_pri, link_sec, output suspended, remote_wake);
endinterface : wlr_core_if
`default_nettype wire

//--- hdl/wlr_poll.sv
// Periodic management poll of link status and the two reported PHY registers
`include "wlr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module wlr_poll #(
	parameter int unsigned POLL_CYCLES = `WLR_POLL_CYCLES
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic srst,
	// Carrier
	wlr_core_if.poll  pif
);
	wlr_pkg::wlr_poll_st_t st;
	wlr_pkg::wlr_poll_st_t next_st;

	// Item 0/1 are the report registers, 2/3 the link status of each PHY
	function automatic logic [9:0] item_addr(input logic [1:0] i);
		unique case (i)
			2'd0: item_addr = {pif.pri_id, pif.rpt_addr[`WLR_RPT_HI_LSB +: 5]};
			2'd1: item_addr = {pif.pri_id, pif.rpt_addr[`WLR_RPT_LO_LSB +: 5]};
			2'd2: item_addr = {pif.pri_id, `WLR_BMSR_ADDR};
			2'd3: item_addr = {pif.sec_id, `WLR_BMSR_ADDR};
		endcase
	endfunction : item_addr

	always_comb begin
		next_st = st;
		unique case (st.state)
			wlr_pkg::WLR_POLL_WAIT: begin
				if (st.timer == 16'h0000) begin
					next_st.state = wlr_pkg::WLR_POLL_ISSUE;
					next_st.idx = 2'd0;
					next_st.req = 1'b1;
					{next_st.phy, next_st.reg_addr} = item_addr(2'd0);
				end else begin
					next_st.timer = st.timer - 16'h0001;
				end
			end
			wlr_pkg::WLR_POLL_ISSUE: begin
				if (pif.mgmt_ack) begin
					unique case (st.idx)
						2'd0: next_st.hi_val = pif.mgmt_rdata;
						2'd1: next_st.lo_val = pif.mgmt_rdata;
						2'd2: next_st.link_pri = pif.mgmt_rdata[`WLR_BMSR_LINK_BIT];
						2'd3: next_st.link_sec = pif.mgmt_rdata[`WLR_BMSR_LINK_BIT];
					endcase
					if (st.idx == 2'd3) begin
						next_st.state = wlr_pkg::WLR_POLL_WAIT;
						next_st.req = 1'b0;
						next_st.timer = 16'(POLL_CYCLES - 1);
					end else begin
						next_st.idx = st.idx + 2'd1;
						{next_st.phy, next_st.reg_addr} = item_addr(st.idx + 2'd1);
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pif.mgmt_req = st.req;
	assign pif.mgmt_phy = st.phy;
	assign pif.mgmt_reg = st.reg_addr;
	assign pif.link_pri = st.link_pri;
	assign pif.link_sec = st.link_sec;
	assign pif.hi_val   = st.hi_val;
	assign pif.lo_val   = st.lo_val;

	property p_hi_capture;
		@(posedge core_clk) disable iff (srst)
		(st.state == wlr_pkg::WLR_POLL_ISSUE && st.idx == 2'd0 && pif.mgmt_ack) |=> (st.hi_val == $past(pif.mgmt_rdata));
	endproperty
	a_hi_capture: assert property (p_hi_capture) else $error("high report value not captured");

	property p_lo_capture;
		@(posedge core_clk) disable iff (srst)
		(st.state == wlr_pkg::WLR_POLL_ISSUE && st.idx == 2'd1 && pif.mgmt_ack) |=> (st.lo_val == $past(pif.mgmt_rdata));
	endproperty
	a_lo_capture: assert property (p_lo_capture) else $error("low report value not captured");
endmodule : wlr_poll
`default_nettype wire

//--- hdl/wlr_wake.sv
// Suspend state and remote wake decision
`include "wlr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module wlr_wake (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic srst,
	// Carrier
	wlr_core_if.wake  wif
);
	wlr_pkg::wlr_wake_st_t st;
	wlr_pkg::wlr_wake_st_t next_st;
	logic [1:0]            link_now;
	logic [1:0]            link_rise;
	logic                  allowed;
	logic                  event_hit;

	assign link_now = {wif.link_sec, wif.link_pri};
	for (genvar g = 0; g < 2; g++) begin : g_rise
		assign link_rise[g] = link_now[g] & ~st.link_q[g];
	end

	assign allowed = wif.remote_wake_flag & wif.setfeat_en;
	assign event_hit = (wif.wake_mp & wif.magic)
		| (wif.wake_lu & (|link_rise))
		| (st.ext_q & ~wif.ext_wake_n);

	always_comb begin
		next_st = st;
		next_st.link_q = link_now;
		next_st.ext_q = wif.ext_wake_n;
		next_st.remote_wake = 1'b0;
		unique case (st.state)
			wlr_pkg::WLR_RUN: begin
				if (wif.suspend_req) begin
					next_st.state = wlr_pkg::WLR_SUSP;
				end
			end
			wlr_pkg::WLR_SUSP: begin
				if (wif.host_resume) begin
					next_st.state = wlr_pkg::WLR_RUN;
				end else if (allowed && event_hit) begin
					next_st.state = wlr_pkg::WLR_WAKE;
					next_st.remote_wake = 1'b1;
				end
			end
			wlr_pkg::WLR_WAKE: begin
				next_st.state = wlr_pkg::WLR_RUN;
			end
			default: begin
				next_st.state = wlr_pkg::WLR_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= '{state: wlr_pkg::WLR_RUN, remote_wake: 1'b0, link_q: 2'b00, ext_q: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	// Bit 0 is low only in RUN, so the flag comes straight from a flop
	assign wif.suspended   = st.state[0];
	assign wif.remote_wake = st.remote_wake;
endmodule : wlr_wake
`default_nettype wire

//--- hdl/wlr_top.sv
// Wake decision, PHY choice and interrupt endpoint report with an APB register slave
//
// The APB register port is this design's own decision.
`include "wlr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module wlr_top #(
	parameter int unsigned POLL_CYCLES = `WLR_POLL_CYCLES
) (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// USB side events
	input  wire logic        usb_suspend_req,
	input  wire logic        host_resume_kj,
	input  wire logic        setfeature_wake_en,
	output logic             suspended,
	output logic             remote_wake_req,
	// Wake sources and status inputs
	input  wire logic        magic_packet_seen,
	input  wire logic        external_wake_pin_n,
	input  wire logic        bulk_out_len_parity_err,
	input  wire logic        phy_interrupt_level,
	// PHY management request port
	output logic             mgmt_req,
	output logic [4:0]       mgmt_phy_addr,
	output logic [4:0]       mgmt_reg_addr,
	input  wire logic        mgmt_ack,
	input  wire logic [15:0] mgmt_rdata,
	// Data path steering and report
	output logic             active_phy_embedded,
	output logic [63:0]      intr_report
);
	wlr_pkg::wlr_top_st_t st;
	wlr_pkg::wlr_top_st_t next_st;
	wlr_core_if           core_if ();
	logic                 access;
	logic                 wr_commit;
	logic [31:0]          rd_word;
	logic                 mapped;

	// Index decode; upper address bits must be zero
	function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
		hit = (a[11:10] == 2'b00) && (a[9:2] == idx);
	endfunction : hit

	wlr_poll #(
		.POLL_CYCLES (POLL_CYCLES)
	) u_poll (
		.core_clk (core_clk),
		.srst     (srst),
		.pif      (core_if.poll)
	);

	wlr_wake u_wake (
		.core_clk (core_clk),
		.srst     (srst),
		.wif      (core_if.wake)
	);

	assign core_if.pri_id      = st.pri_id;
	assign core_if.sec_id      = st.sec_id;
	assign core_if.rpt_addr    = st.rpt_addr;
	assign core_if.mgmt_ack    = mgmt_ack;
	assign core_if.mgmt_rdata  = mgmt_rdata;
	assign core_if.remote_wake_flag         = st.remote_wake_flag;
	assign core_if.setfeat_en  = setfeature_wake_en;
	assign core_if.wake_lu     = st.wake_lu;
	assign core_if.wake_mp     = st.wake_mp;
	assign core_if.magic       = magic_packet_seen;
	assign core_if.host_resume = host_resume_kj;
	assign core_if.suspend_req = usb_suspend_req;
	assign core_if.ext_wake_n  = external_wake_pin_n;

	// One wait state so that read data comes from a flop
	assign access = psel && penable && !st.pready;
	assign wr_commit = psel && penable && st.pready && pwrite && !st.pslverr;

	always_comb begin
		rd_word = 32'h0000_0000;
		mapped = 1'b1;
		if (hit(paddr, `WLR_IDX_PHY_STAT)) begin
			rd_word[`WLR_AUTO_PHY_SELECT_BIT] = st.auto_sel;
			rd_word[`WLR_PSEL_BIT] = st.phy_sel;
		end else if (hit(paddr, `WLR_IDX_PHY_CTL) || hit(paddr, `WLR_IDX_MON) || hit(paddr, `WLR_IDX_SWRST)) begin
			rd_word = 32'h0000_0000;
		end else if (hit(paddr, `WLR_IDX_CFG)) begin
			rd_word[`WLR_CFG_PRI_LSB +: `WLR_PHY_ID_W] = st.pri_id;
			rd_word[`WLR_CFG_SEC_LSB +: `WLR_PHY_ID_W] = st.sec_id;
			rd_word[`WLR_CFG_RWU_BIT] = st.remote_wake_flag;
		end else if (hit(paddr, `WLR_IDX_RPT)) begin
			rd_word[15:0] = st.rpt_addr;
		end else if (hit(paddr, `WLR_IDX_STAT)) begin
			rd_word[`WLR_ST_PRI_BIT] = core_if.link_pri;
			rd_word[`WLR_ST_SEC_BIT] = core_if.link_sec;
			rd_word[`WLR_ST_FLE_BIT] = st.frame_length_error;
			rd_word[`WLR_ST_INT_BIT] = st.phy_int;
			rd_word[`WLR_ST_EMB_BIT] = st.emb_active;
			rd_word[`WLR_ST_SUSP_BIT] = core_if.suspended;
		end else begin
			mapped = 1'b0;
		end
	end

	always_comb begin
		next_st = st;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		if (access) begin
			next_st.pready = 1'b1;
			next_st.pslverr = !mapped;
			next_st.prdata = pwrite ? 32'h0000_0000 : rd_word;
		end
		if (wr_commit) begin
			if (hit(paddr, `WLR_IDX_PHY_CTL)) begin
				next_st.auto_sel = pwdata[`WLR_AUTO_PHY_SELECT_BIT];
				next_st.phy_sel = pwdata[`WLR_PSEL_BIT];
			end
			if (hit(paddr, `WLR_IDX_MON)) begin
				next_st.wake_lu = pwdata[`WLR_WAKE_ON_LINKUP_BIT];
				next_st.wake_mp = pwdata[`WLR_WAKE_ON_MAGIC_BIT];
			end
			if (hit(paddr, `WLR_IDX_SWRST)) begin
				next_st.clr_bo = pwdata[`WLR_CLRBO_BIT];
			end
			if (hit(paddr, `WLR_IDX_CFG)) begin
				next_st.pri_id = pwdata[`WLR_CFG_PRI_LSB +: `WLR_PHY_ID_W];
				next_st.sec_id = pwdata[`WLR_CFG_SEC_LSB +: `WLR_PHY_ID_W];
				next_st.remote_wake_flag = pwdata[`WLR_CFG_RWU_BIT];
			end
			if (hit(paddr, `WLR_IDX_RPT)) begin
				next_st.rpt_addr = pwdata[15:0];
			end
		end
		// Held clear wins over a new error, as the clear state is a level
		if (st.clr_bo) begin
			next_st.frame_length_error = 1'b0;
		end else if (bulk_out_len_parity_err) begin
			next_st.frame_length_error = 1'b1;
		end
		next_st.phy_int = phy_interrupt_level;
		// Manual choice, or embedded PHY while its link is up
		next_st.emb_active = st.auto_sel ? core_if.link_pri : st.phy_sel;
		next_st.report = {`WLR_RPT_HDR, `WLR_RPT_PAD,
			4'h0, st.phy_int, st.frame_length_error, core_if.link_sec, core_if.link_pri,
			`WLR_RPT_PAD,
			core_if.hi_val,
			core_if.lo_val};
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000,
				auto_sel: `WLR_AUTO_PHY_SELECT_RST, phy_sel: `WLR_PSEL_RST,
				wake_lu: `WLR_WAKE_EN_RST, wake_mp: `WLR_WAKE_EN_RST, clr_bo: 1'b0,
				pri_id: `WLR_PRI_ID_RST, sec_id: `WLR_SEC_ID_RST, remote_wake_flag: 1'b0,
				rpt_addr: `WLR_RPT_ADDR_RST, frame_length_error: 1'b0, phy_int: 1'b0, emb_active: 1'b1,
				report: {`WLR_RPT_HDR, `WLR_RPT_PAD, `WLR_RPT_PAD, `WLR_RPT_PAD, 32'h0000_0000}};
		end else begin
			st <= next_st;
		end
	end

	assign pready              = st.pready;
	assign prdata              = st.prdata;
	assign pslverr             = st.pslverr;
	assign suspended           = core_if.suspended;
	assign remote_wake_req     = core_if.remote_wake;
	assign mgmt_req            = core_if.mgmt_req;
	assign mgmt_phy_addr       = core_if.mgmt_phy;
	assign mgmt_reg_addr       = core_if.mgmt_reg;
	assign active_phy_embedded = st.emb_active;
	assign intr_report         = st.report;

	property p_apb_one_wait;
		@(posedge core_clk) disable iff (srst)
		(psel && penable && !pready) |=> pready ##1 !pready;
	endproperty
	a_apb_one_wait: assert property (p_apb_one_wait) else $error("APB answer not one wait state");

	property p_manual_embedded;
		@(posedge core_clk) disable iff (srst)
		(!st.auto_sel && st.phy_sel) |=> active_phy_embedded;
	endproperty
	a_manual_embedded: assert property (p_manual_embedded) else $error("manual select 1 not embedded");

	property p_manual_external;
		@(posedge core_clk) disable iff (srst)
		(!st.auto_sel && !st.phy_sel) |=> !active_phy_embedded;
	endproperty
	a_manual_external: assert property (p_manual_external) else $error("manual select 0 not external");

	property p_auto_follows_link;
		@(posedge core_clk) disable iff (srst)
		st.auto_sel |=> (active_phy_embedded == $past(core_if.link_pri));
	endproperty
	a_auto_follows_link: assert property (p_auto_follows_link) else $error("auto select ignores link");

	property p_ctl_to_status;
		@(posedge core_clk) disable iff (srst)
		(wr_commit && hit(paddr, `WLR_IDX_PHY_CTL))
			|=> (st.auto_sel == $past(pwdata[`WLR_AUTO_PHY_SELECT_BIT]) && st.phy_sel == $past(pwdata[`WLR_PSEL_BIT]));
	endproperty
	a_ctl_to_status: assert property (p_ctl_to_status) else $error("selection write lost");

	property p_ctl_reads_zero;
		@(posedge core_clk) disable iff (srst)
		(access && !pwrite && hit(paddr, `WLR_IDX_PHY_CTL)) |=> (prdata == 32'h0000_0000 && !pslverr);
	endproperty
	a_ctl_reads_zero: assert property (p_ctl_reads_zero) else $error("write-only selection readable");

	property p_host_resume;
		@(posedge core_clk) disable iff (srst)
		(core_if.suspended && !core_if.remote_wake && host_resume_kj) |=> !suspended;
	endproperty
	a_host_resume: assert property (p_host_resume) else $error("host resume did not wake");

	property p_no_self_wake;
		@(posedge core_clk) disable iff (srst)
		!(st.remote_wake_flag && setfeature_wake_en) |=> !remote_wake_req;
	endproperty
	a_no_self_wake: assert property (p_no_self_wake) else $error("self wake without permission");

	property p_magic_wake;
		@(posedge core_clk) disable iff (srst)
		(suspended && !remote_wake_req && !host_resume_kj && st.remote_wake_flag && setfeature_wake_en
			&& st.wake_mp && magic_packet_seen) |=> remote_wake_req;
	endproperty
	a_magic_wake: assert property (p_magic_wake) else $error("magic packet did not wake");

	property p_ext_wake;
		@(posedge core_clk) disable iff (srst)
		(suspended && !remote_wake_req && st.remote_wake_flag && setfeature_wake_en && $fell(external_wake_pin_n))
			|=> (remote_wake_req || !suspended);
	endproperty
	a_ext_wake: assert property (p_ext_wake) else $error("external pin did not wake");

	property p_linkup_wake;
		@(posedge core_clk) disable iff (srst)
		(suspended && !remote_wake_req && !host_resume_kj && st.remote_wake_flag && setfeature_wake_en && st.wake_lu
			&& ($rose(core_if.link_pri) || $rose(core_if.link_sec))) |=> remote_wake_req;
	endproperty
	a_linkup_wake: assert property (p_linkup_wake) else $error("link-up did not wake");

	property p_report_frame;
		@(posedge core_clk) disable iff (srst)
		1'b1 |=> (intr_report[63:56] == `WLR_RPT_HDR && intr_report[55:48] == `WLR_RPT_PAD
			&& intr_report[39:32] == `WLR_RPT_PAD && intr_report[47:44] == 4'h0);
	endproperty
	a_report_frame: assert property (p_report_frame) else $error("report frame malformed");

	property p_report_status;
		@(posedge core_clk) disable iff (srst)
		1'b1 |=> (intr_report[`WLR_RPT_STAT_LSB +: 2] == $past({core_if.link_sec, core_if.link_pri})
			&& intr_report[31:16] == $past(core_if.hi_val) && intr_report[15:0] == $past(core_if.lo_val));
	endproperty
	a_report_status: assert property (p_report_status) else $error("report status stale");

	property p_int_level;
		@(posedge core_clk) disable iff (srst)
		phy_interrupt_level |-> ##2 intr_report[`WLR_RPT_STAT_LSB + `WLR_ST_INT_BIT];
	endproperty
	a_int_level: assert property (p_int_level) else $error("PHY interrupt level not reported");

	property p_fle_set;
		@(posedge core_clk) disable iff (srst)
		(bulk_out_len_parity_err && !st.clr_bo) |=> st.frame_length_error ##1 intr_report[`WLR_RPT_STAT_LSB + `WLR_ST_FLE_BIT];
	endproperty
	a_fle_set: assert property (p_fle_set) else $error("length error not flagged");

	property p_fle_clear;
		@(posedge core_clk) disable iff (srst)
		st.clr_bo |=> !st.frame_length_error;
	endproperty
	a_fle_clear: assert property (p_fle_clear) else $error("length error survives clear");

	property p_mon_write;
		@(posedge core_clk) disable iff (srst)
		(wr_commit && hit(paddr, `WLR_IDX_MON)) |=> (st.wake_lu == $past(pwdata[`WLR_WAKE_ON_LINKUP_BIT]));
	endproperty
	a_mon_write: assert property (p_mon_write) else $error("monitor write lost");

	property p_mon_magic_write;
		@(posedge core_clk) disable iff (srst)
		(wr_commit && hit(paddr, `WLR_IDX_MON)) |=> (st.wake_mp == $past(pwdata[`WLR_WAKE_ON_MAGIC_BIT]));
	endproperty
	a_mon_magic_write: assert property (p_mon_magic_write) else $error("magic enable write lost");

	property p_int_mirror;
		@(posedge core_clk) disable iff (srst)
		1'b1 |-> ##2 (intr_report[`WLR_RPT_STAT_LSB + `WLR_ST_INT_BIT] == $past(phy_interrupt_level, 2));
	endproperty
	a_int_mirror: assert property (p_int_mirror) else $error("PHY interrupt level not mirrored");

	property p_unmapped_error;
		@(posedge core_clk) disable iff (srst)
		(access && !mapped) |=> (pslverr && prdata == 32'h0000_0000);
	endproperty
	a_unmapped_error: assert property (p_unmapped_error) else $error("unmapped access not refused");

	property p_mgmt_hold;
		@(posedge core_clk) disable iff (srst)
		(mgmt_req && !mgmt_ack) |=> (mgmt_req && $stable(mgmt_phy_addr) && $stable(mgmt_reg_addr));
	endproperty
	a_mgmt_hold: assert property (p_mgmt_hold) else $error("management request dropped early");

	property p_wake_returns;
		@(posedge core_clk) disable iff (srst)
		remote_wake_req |-> suspended ##1 (!suspended && !remote_wake_req);
	endproperty
	a_wake_returns: assert property (p_wake_returns) else $error("remote wake did not return to run");

	c_remote_wake: cover property (@(posedge core_clk) disable iff (srst) remote_wake_req);
	c_host_resume: cover property (@(posedge core_clk) disable iff (srst) suspended && host_resume_kj);
	c_ctl_write: cover property (@(posedge core_clk) disable iff (srst) wr_commit && hit(paddr, `WLR_IDX_PHY_CTL));
	c_fle: cover property (@(posedge core_clk) disable iff (srst) $rose(st.frame_length_error));
	c_linkup_wake: cover property (@(posedge core_clk) disable iff (srst) suspended && $rose(core_if.link_pri));
endmodule : wlr_top
`default_nettype wire

//--- test/wlr_mgmt_model.sv
// Management responder standing in for the PHYs behind the poll port
`include "wlr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module wlr_mgmt_model (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// Poll port
	input  wire logic        mgmt_req,
	input  wire logic [4:0]  phy,
	input  wire logic [4:0]  reg_a,
	output logic             ack,
	output logic [15:0]      rdata,
	// Link levels set by the bench
	input  wire logic        link_pri,
	input  wire logic        link_sec
);
	logic busy;
	always_ff @(posedge core_clk) begin
		ack   <= 1'b0;
		rdata <= ~rdata;
		if (srst) begin
			busy  <= 1'b0;
			rdata <= 16'h5a5a;
		end else if (busy) begin
			busy <= 1'b0;
			ack  <= 1'b1;
			if (reg_a == `WLR_BMSR_ADDR)
				rdata <= {13'h0, (phy == `WLR_PRI_ID_RST) ? link_pri : link_sec, 2'h0};
			else
				rdata <= {3'h5, phy, 3'h2, reg_a};
		end else if (mgmt_req && !ack)
			busy <= 1'b1; // Slow answer: one wait cycle
	end
endmodule : wlr_mgmt_model
`default_nettype wire

//--- test/wlr_top_bench.sv
// Self-checking bench of the wake and link report block
`include "wlr_defines.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module wlr_top_bench;
	logic        core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, q, prdata;
	logic        pready, pslverr, e, suspended, rwr, mreq, ack, emb, seen;
	logic [4:0]  mphy, mreg;
	logic [15:0] mdat;
	logic [63:0] rpt;
	logic        sreq = 0, res = 0, fen = 0, mag = 0, ext_n = 1, perr = 0, pint = 0, lp = 0, ls = 0;
	int          errors = 0, checked = 0;
	wlr_top #(.POLL_CYCLES(20)) dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.usb_suspend_req(sreq), .host_resume_kj(res), .setfeature_wake_en(fen), .suspended(suspended),
		.remote_wake_req(rwr), .magic_packet_seen(mag), .external_wake_pin_n(ext_n),
		.bulk_out_len_parity_err(perr), .phy_interrupt_level(pint), .mgmt_req(mreq), .mgmt_phy_addr(mphy),
		.mgmt_reg_addr(mreg), .mgmt_ack(ack), .mgmt_rdata(mdat), .active_phy_embedded(emb), .intr_report(rpt));
	wlr_mgmt_model phy_side (.core_clk(core_clk), .srst(srst), .mgmt_req(mreq), .phy(mphy), .reg_a(mreg),
		.ack(ack), .rdata(mdat), .link_pri(lp), .link_sec(ls));
	initial forever #20 core_clk = ~core_clk;
	task automatic stop_test;
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask : wt
	task automatic apb(input bit w, input logic [7:0] i, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {2'h0, i, 2'h0};
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Idle edge so that a following call never reassigns psel in this time step
		@(posedge core_clk);
	endtask : apb
	task automatic rd(input logic [7:0] i, input logic [31:0] x);
		apb(1'b0, i, 32'h0);
		`CHK(q, x)
	endtask : rd
	// Kinds: 0 magic, 1 wake pin, 2 primary link-up, 3 host resume
	task automatic wk(input int s, input logic x);
		sreq <= 1'b1;
		wt(1);
		sreq <= 1'b0;
		wt(3);
		`CHK(suspended, 1'b1)
		case (s)
			0: mag <= 1'b1;
			1: ext_n <= 1'b0;
			2: lp <= 1'b1;
			default: res <= 1'b1;
		endcase
		wt(1);
		mag   <= 1'b0;
		ext_n <= 1'b1;
		res   <= 1'b0;
		seen = 1'b0;
		repeat (80) begin
			@(posedge core_clk);
			seen = seen | rwr;
		end
		`CHK(seen, x)
		if (!x) begin
			res <= 1'b1;
			wt(1);
			res <= 1'b0;
			wt(3);
		end
		`CHK(suspended, 1'b0)
	endtask : wk
	initial begin
		wt(20000);
		errors++;
		stop_test;
	end
	initial begin
		wt(5);
		`CHK(rpt, 64'ha100_0000_0000_0000)
		srst <= 1'b0;
		wt(1);
		rd(`WLR_IDX_PHY_STAT, 32'h3);
		rd(`WLR_IDX_PHY_CTL, 32'h0);
		rd(8'h05, 32'h0);
		`CHK(e, 1'b1)
		wt(80);
		`CHK(emb, 1'b0)
		lp   <= 1'b1;
		ls   <= 1'b1;
		pint <= 1'b1;
		apb(1'b1, `WLR_IDX_RPT, 32'h0302);
		wt(80);
		`CHK(emb, 1'b1)
		`CHK(rpt, 64'ha100_0b00_b043_b042)
		rd(`WLR_IDX_STAT, 32'h1b);
		apb(1'b1, `WLR_IDX_PHY_CTL, 32'h0);
		wt(3);
		`CHK(emb, 1'b0)
		rd(`WLR_IDX_PHY_STAT, 32'h0);
		apb(1'b1, `WLR_IDX_PHY_CTL, 32'h1);
		wt(3);
		`CHK(emb, 1'b1)
		perr <= 1'b1;
		wt(1);
		perr <= 1'b0;
		wt(3);
		`CHK(rpt[42], 1'b1)
		apb(1'b1, `WLR_IDX_SWRST, 32'h2);
		wt(3);
		`CHK(rpt[42], 1'b0)
		apb(1'b1, `WLR_IDX_SWRST, 32'h0);
		lp   <= 1'b0;
		ls   <= 1'b0;
		pint <= 1'b0;
		wt(80);
		`CHK(rpt[47:40], 8'h00)
		apb(1'b1, `WLR_IDX_MON, 32'h6);
		apb(1'b1, `WLR_IDX_CFG, 32'h0110);
		wk(0, 1'b0);
		wk(1, 1'b0);
		fen <= 1'b1;
		apb(1'b1, `WLR_IDX_CFG, 32'h1_0110);
		rd(`WLR_IDX_CFG, 32'h1_0110);
		apb(1'b1, `WLR_IDX_MON, 32'h2);
		wk(0, 1'b0);
		wk(2, 1'b1);
		apb(1'b1, `WLR_IDX_MON, 32'h4);
		wk(0, 1'b1);
		apb(1'b1, `WLR_IDX_MON, 32'h0);
		wk(1, 1'b1);
		wk(3, 1'b0);
		stop_test;
	end
endmodule : wlr_top_bench
`default_nettype wire
